// ---- core/ppd_ctrl.sv ----
`timescale 1ns/1ns

`include "ppd_regs.svh"

module ppd_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PPD_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port1_pin_in,
    output logic [7:0] port1_pin_out,
    output logic [7:0] port1_pin_oe,
    output logic [7:0] port1_pull_en,
    input wire logic [4:0] port2_pin_in,
    output logic [4:0] port2_pin_out,
    output logic [4:0] port2_pin_oe,
    input wire logic [7:0] port3_pin_in,
    output logic [7:0] port3_pin_out,
    output logic [7:0] port3_pin_oe,
    output logic [7:0] port3_pull_en,
    input wire logic [2:0] port4_pin_in,
    output logic [2:0] port4_pin_out,
    output logic [2:0] port4_pin_oe,
    input wire logic [7:0] port5_pin_in,
    output logic [7:0] port5_pin_out,
    output logic [7:0] port5_pin_oe,
    output logic [7:0] port5_pull_en,
    input wire logic [7:0] port6_pin_in,
    output logic [7:0] port6_pin_out,
    output logic [7:0] port6_pin_oe,
    output logic [7:0] port6_pull_en
);
    import ppd_pkg::*;

    // ----------------------------------------
    // constants
    // ----------------------------------------
    // implemented pins, port 6 down to port 1
    localparam ppd_bytes_t IMPL = {`PPD_MASK_FULL, `PPD_MASK_FULL, `PPD_MASK_P4,
        `PPD_MASK_FULL, `PPD_MASK_P2, `PPD_MASK_FULL};
    // pins that own a pull-up: ports 1,3,5,6 only
    localparam ppd_bytes_t PULLABLE = {`PPD_MASK_FULL, `PPD_MASK_FULL, `PPD_MASK_NONE,
        `PPD_MASK_FULL, `PPD_MASK_NONE, `PPD_MASK_FULL};
    localparam logic [2:0] PORT1 = 3'h0;
    localparam logic [2:0] PORT3 = 3'h2;
    localparam logic [2:0] PORT5 = 3'h4;
    localparam logic [2:0] PORT6 = 3'h5;

    // ----------------------------------------
    // decoding helpers
    // ----------------------------------------
    // class of the register at an index
    function automatic ppd_kind_t dec_kind(input logic [7:0] idx);
        ppd_kind_t k;
        k = PPD_KIND_NONE;
        if (idx >= `PPD_IDX_DATA_P1 && idx <= `PPD_IDX_DATA_P6) begin
            k = PPD_KIND_DATA;
        end else if (idx >= `PPD_IDX_PULL_P1 && idx <= `PPD_IDX_PULL_P6) begin
            k = PPD_KIND_PULL;
        end else if (idx >= `PPD_IDX_DIR_P1 && idx <= `PPD_IDX_DIR_P6) begin
            k = PPD_KIND_DIR;
        end
        return k;
    endfunction

    // port number (0 = port 1) of the register at an index
    function automatic logic [2:0] dec_port(input logic [7:0] idx);
        logic [2:0] p;
        logic [7:0] diff;
        p = 3'h0;
        diff = 8'h00;
        case (idx)
            `PPD_IDX_PULL_P1: p = PORT1;
            `PPD_IDX_PULL_P3: p = PORT3;
            `PPD_IDX_PULL_P5: p = PORT5;
            `PPD_IDX_PULL_P6: p = PORT6;
            default: begin
                if (idx >= `PPD_IDX_DIR_P1) begin
                    diff = idx - `PPD_IDX_DIR_P1;
                end else begin
                    diff = idx - `PPD_IDX_DATA_P1;
                end
                p = diff[2:0];
            end
        endcase
        return p;
    endfunction

    // ----------------------------------------
    // state and bus decode
    // ----------------------------------------
    ppd_state_t st_q;
    ppd_state_t st_d;

    logic [7:0] bus_idx;
    ppd_kind_t bus_kind;
    logic [2:0] bus_port;
    logic bus_setup;
    logic bus_wr;
    logic bus_bad;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;

    // pin-side views, one byte per port
    ppd_bytes_t pin_in_a;
    ppd_bytes_t pin_out_a;
    ppd_bytes_t pin_oe_a;
    ppd_bytes_t pull_a;
    ppd_bytes_t sync_a;

    assign bus_idx = paddr[`PPD_IDX_MSB:`PPD_IDX_LSB];
    assign bus_kind = dec_kind(bus_idx);
    assign bus_port = dec_port(bus_idx);
    assign bus_setup = psel & ~penable;
    assign bus_wr = psel & penable & pwrite;
    assign wr_byte = pwdata[7:0];

    // unmapped, misaligned or beyond the decoded window
    assign bus_bad = (bus_kind == PPD_KIND_NONE) || (paddr[1:0] != 2'b00)
        || (paddr[`PPD_ADDR_W-1:`PPD_IDX_MSB+1] != '0);

    // read value; missing bits read as one
    always_comb begin
        case (bus_kind)
            PPD_KIND_PULL: rd_byte = st_q.pull[bus_port];
            PPD_KIND_DIR: rd_byte = ~IMPL[bus_port];
            PPD_KIND_DATA: rd_byte = ~IMPL[bus_port]
                | (st_q.dir[bus_port] & st_q.dat[bus_port])
                | (~st_q.dir[bus_port] & sync_a[bus_port] & IMPL[bus_port]);
            default: rd_byte = 8'h00;
        endcase
    end

    // ----------------------------------------
    // register update
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        // answer prepared in the setup cycle
        if (bus_setup) begin
            st_d.err = bus_bad;
            st_d.rdata = (pwrite || bus_bad) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
        // write takes effect at the access edge, lane 0 only
        if (bus_wr && !st_q.err && pstrb[0]) begin
            case (bus_kind)
                PPD_KIND_PULL: st_d.pull[bus_port] = wr_byte & PULLABLE[bus_port];
                PPD_KIND_DIR: st_d.dir[bus_port] = wr_byte & IMPL[bus_port];
                PPD_KIND_DATA: st_d.dat[bus_port] = wr_byte & IMPL[bus_port];
                default: st_d.err = st_q.err;
            endcase
        end
    end

    // all pull-ups off, all pins input after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.pull <= {`PPD_NPORT{`PPD_RST_PULL}};
            st_q.dir <= {`PPD_NPORT{`PPD_RST_DIR}};
            st_q.dat <= {`PPD_NPORT{`PPD_RST_DATA}};
            st_q.rdata <= 32'h0000_0000;
            st_q.err <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // zero-wait slave
    assign pready = 1'b1;
    assign prdata = st_q.rdata;
    assign pslverr = st_q.err;

    // ----------------------------------------
    // pin cells
    // ----------------------------------------
    assign pin_in_a[0] = port1_pin_in;
    assign pin_in_a[1] = {3'h0, port2_pin_in};
    assign pin_in_a[2] = port3_pin_in;
    assign pin_in_a[3] = {5'h00, port4_pin_in};
    assign pin_in_a[4] = port5_pin_in;
    assign pin_in_a[5] = port6_pin_in;

    // one cell per port: drive, enable, gated pull-up
    for (genvar g = 0; g < `PPD_NPORT; g++) begin : g_port
        ppd_pin_cell #(
            .W(8)
        ) u_cell (
            .pclk(pclk),
            .presetn(presetn),
            .dir_en(st_q.dir[g]),
            .out_val(st_q.dat[g]),
            .pull_req(st_q.pull[g]),
            .pin_in(pin_in_a[g]),
            .pin_out(pin_out_a[g]),
            .pin_oe(pin_oe_a[g]),
            .pull_on(pull_a[g]),
            .pin_sync(sync_a[g])
        );
    end

    // pull-ups gated by input direction inside the cells
    assign port1_pull_en = pull_a[0];
    assign port3_pull_en = pull_a[2];
    assign port5_pull_en = pull_a[4];
    assign port6_pull_en = pull_a[5];

    assign port1_pin_out = pin_out_a[0];
    assign port1_pin_oe = pin_oe_a[0];
    assign port2_pin_out = pin_out_a[1][4:0];
    assign port2_pin_oe = pin_oe_a[1][4:0];
    assign port3_pin_out = pin_out_a[2];
    assign port3_pin_oe = pin_oe_a[2];
    assign port4_pin_out = pin_out_a[3][2:0];
    assign port4_pin_oe = pin_oe_a[3][2:0];
    assign port5_pin_out = pin_out_a[4];
    assign port5_pin_oe = pin_oe_a[4];
    assign port6_pin_out = pin_out_a[5];
    assign port6_pin_oe = pin_oe_a[5];

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // good write and read setup to one index
    sequence s_write(logic [7:0] idx);
        bus_wr && !st_q.err && pstrb[0] && bus_idx == idx;
    endsequence

    sequence s_read(logic [7:0] idx);
        bus_setup && !pwrite && !bus_bad && bus_idx == idx;
    endsequence

    // on ports 1 and 5 an enabled pull-up never meets a driven pin
    chk_pull_vs_drive: assert property ((port1_pull_en & port1_pin_oe) == 8'h00
        && (port5_pull_en & port5_pin_oe) == 8'h00)
        else $error("pull-up active on an output pin");

    // pull-up write reaches the pin two edges later
    chk_pull_write: assert property (s_write(`PPD_IDX_PULL_P1) ##0 st_q.dir[0] == 8'h00
        |=> ##1 port1_pull_en == $past(wr_byte, 2))
        else $error("port 1 pull-up not applied");

    // pull-up value reads back as written
    chk_pull_read: assert property (s_read(`PPD_IDX_PULL_P3)
        |=> prdata[7:0] == $past(st_q.pull[2]) && !pslverr)
        else $error("port 3 pull-up readback wrong");

    // direction write sets the enables
    chk_dir_oe: assert property (s_write(`PPD_IDX_DIR_P3)
        |=> ##1 port3_pin_oe == $past(wr_byte, 2))
        else $error("port 3 direction not applied");

    // write-only direction reads as zero on a full port
    chk_dir1_read: assert property (s_read(`PPD_IDX_DIR_P1)
        |=> prdata == 32'h0000_0000)
        else $error("port 1 direction readback not zero");

    // unused port 2 direction bits read as one
    chk_dir2_unused: assert property (s_read(`PPD_IDX_DIR_P2)
        |=> prdata[7:0] == 8'hE0)
        else $error("port 2 direction unused bits wrong");

    // unused port 4 direction bits read as one, pins stay in
    chk_dir4_unused: assert property (s_read(`PPD_IDX_DIR_P4)
        |=> prdata[7:0] == 8'hF8 && st_q.dir[3][7:3] == 5'h00)
        else $error("port 4 direction unused bits wrong");

    // port 5 pull-up stays off while all pins drive
    chk_p5_masked: assert property (s_write(`PPD_IDX_PULL_P5) ##0 st_q.dir[4] == 8'hFF
        |=> ##1 port5_pull_en == 8'h00 [*2])
        else $error("port 5 pull-up leaked on outputs");

    // data write appears on a driven pin
    chk_data_out: assert property (s_write(`PPD_IDX_DATA_P1) ##0 st_q.dir[0] == 8'hFF
        |=> ##1 port1_pin_out == $past(wr_byte, 2))
        else $error("port 1 output not from data");

endmodule

// ---- core/ppd_pin_cell.sv ----
`timescale 1ns/1ns

// ----------------------------------------
// per-port pin cell
// ----------------------------------------
module ppd_pin_cell #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] dir_en,
    input wire logic [W-1:0] out_val,
    input wire logic [W-1:0] pull_req,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] pull_on,
    output logic [W-1:0] pin_sync
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] out;
        logic [W-1:0] oe;
        logic [W-1:0] pull;
    } ppd_cell_t;

    ppd_cell_t cq_q;
    ppd_cell_t cq_d;

    if (W < 1 || W > 8) begin : g_bad_w
        $error("ppd_pin_cell: W must be 1 to 8");
    end

    // next state: sync chain and pin drivers
    always_comb begin
        cq_d = cq_q;
        cq_d.s1 = pin_in;
        cq_d.s2 = cq_q.s1;
        cq_d.oe = dir_en;
        cq_d.out = out_val & dir_en;
        cq_d.pull = pull_req & ~dir_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cq_q <= '0;
        end else begin
            cq_q <= cq_d;
        end
    end

    assign pin_out = cq_q.out;
    assign pin_oe = cq_q.oe;
    assign pull_on = cq_q.pull;
    assign pin_sync = cq_q.s2;

endmodule

// ---- core/ppd_pkg.sv ----
`include "ppd_regs.svh"

package ppd_pkg;

    // register class selected by an index
    typedef enum logic [1:0] {
        PPD_KIND_NONE = 2'b00,
        PPD_KIND_PULL = 2'b01,
        PPD_KIND_DIR = 2'b11,
        PPD_KIND_DATA = 2'b10
    } ppd_kind_t;

    typedef logic [`PPD_NPORT-1:0][7:0] ppd_bytes_t;

    // whole state of the controller
    typedef struct packed {
        ppd_bytes_t pull;
        ppd_bytes_t dir;
        ppd_bytes_t dat;
        logic [31:0] rdata;
        logic err;
    } ppd_state_t;

endpackage

// ---- core/ppd_regs.svh ----
`ifndef PPD_REGS_SVH
`define PPD_REGS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define PPD_IDX_DATA_P1 8'hD4
`define PPD_IDX_DATA_P6 8'hD9
`define PPD_IDX_PULL_P1 8'hE0
`define PPD_IDX_PULL_P3 8'hE1
`define PPD_IDX_PULL_P5 8'hE2
`define PPD_IDX_PULL_P6 8'hE3
`define PPD_IDX_DIR_P1 8'hE4
`define PPD_IDX_DIR_P2 8'hE5
`define PPD_IDX_DIR_P3 8'hE6
`define PPD_IDX_DIR_P4 8'hE7
`define PPD_IDX_DIR_P6 8'hE9

// ----------------------------------------
// bus layout
// ----------------------------------------
`define PPD_ADDR_W 12
`define PPD_IDX_LSB 2
`define PPD_IDX_MSB 9
`define PPD_NPORT 6

// ----------------------------------------
// implemented pins per port
// ----------------------------------------
`define PPD_MASK_FULL 8'hFF
`define PPD_MASK_P2 8'h1F
`define PPD_MASK_P4 8'h07
`define PPD_MASK_NONE 8'h00

// ----------------------------------------
// reset values
// ----------------------------------------
`define PPD_RST_PULL 8'h00
`define PPD_RST_DIR 8'h00
`define PPD_RST_DATA 8'h00

`endif

// ---- testbench/ppd_board.sv ----
`timescale 1ns/1ns

// ----------------------------------------
// board circuitry on one port
// ----------------------------------------
module ppd_board #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] pull,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext,
    output logic [W-1:0] pin
);
    logic [W-1:0] last_q = '0;

    // a floating pin never repeats its old level
    always_ff @(posedge pclk) begin
        last_q <= pin;
    end

    // pin level: device drive, then board drive, then pull-up, else floating
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin[i] = oe[i] ? out[i] : ext_en[i] ? ext[i] : pull[i] ? 1'b1 : ~last_q[i];
        end
    end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
`include "ppd_regs.svh"

module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, er;
    logic [7:0] pin_in [6], pin_out [6], pin_oe [6], pull_en [6], ext [6], ext_en [6];
    int failures = 0, total_checks = 0, seed = 57301;
    int pull_m [6], dir_m [6], dat_m [6];
    int mask_m [6] = '{255, 31, 255, 7, 255, 255};
    int pull_ix [6] = '{224, 0, 225, 0, 226, 227};
    int has_pull [6] = '{1, 0, 1, 0, 1, 1};

    always #20 pclk = ~pclk;
    assign pull_en[1] = 8'h00;
    assign pull_en[3] = 8'h00;

    ppd_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port1_pin_in(pin_in[0]), .port1_pin_out(pin_out[0]), .port1_pin_oe(pin_oe[0]), .port1_pull_en(pull_en[0]),
        .port2_pin_in(pin_in[1][4:0]), .port2_pin_out(pin_out[1][4:0]), .port2_pin_oe(pin_oe[1][4:0]),
        .port3_pin_in(pin_in[2]), .port3_pin_out(pin_out[2]), .port3_pin_oe(pin_oe[2]), .port3_pull_en(pull_en[2]),
        .port4_pin_in(pin_in[3][2:0]), .port4_pin_out(pin_out[3][2:0]), .port4_pin_oe(pin_oe[3][2:0]),
        .port5_pin_in(pin_in[4]), .port5_pin_out(pin_out[4]), .port5_pin_oe(pin_oe[4]), .port5_pull_en(pull_en[4]),
        .port6_pin_in(pin_in[5]), .port6_pin_out(pin_out[5]), .port6_pin_oe(pin_oe[5]), .port6_pull_en(pull_en[5]));

    // board models, one per port
    ppd_board b1 (.pclk(pclk), .oe(pin_oe[0]), .out(pin_out[0]), .pull(pull_en[0]),
        .ext_en(ext_en[0]), .ext(ext[0]), .pin(pin_in[0]));
    ppd_board #(.W(5)) b2 (.pclk(pclk), .oe(pin_oe[1][4:0]), .out(pin_out[1][4:0]), .pull(pull_en[1][4:0]),
        .ext_en(ext_en[1][4:0]), .ext(ext[1][4:0]), .pin(pin_in[1][4:0]));
    ppd_board b3 (.pclk(pclk), .oe(pin_oe[2]), .out(pin_out[2]), .pull(pull_en[2]),
        .ext_en(ext_en[2]), .ext(ext[2]), .pin(pin_in[2]));
    ppd_board #(.W(3)) b4 (.pclk(pclk), .oe(pin_oe[3][2:0]), .out(pin_out[3][2:0]), .pull(pull_en[3][2:0]),
        .ext_en(ext_en[3][2:0]), .ext(ext[3][2:0]), .pin(pin_in[3][2:0]));
    ppd_board b5 (.pclk(pclk), .oe(pin_oe[4]), .out(pin_out[4]), .pull(pull_en[4]),
        .ext_en(ext_en[4]), .ext(ext[4]), .pin(pin_in[4]));
    ppd_board b6 (.pclk(pclk), .oe(pin_oe[5]), .out(pin_out[5]), .pull(pull_en[5]),
        .ext_en(ext_en[5]), .ext(ext[5]), .pin(pin_in[5]));

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one transfer; request held until pready seen high, left standing
    task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 16) failures++;
        rd = prdata;
        er = pslverr;
    endtask

    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [11:0] adr(input int idx);
        return {2'b00, idx[7:0], 2'b00};
    endfunction

    // pin outputs against the model, sampled mid-cycle, ends on a rising edge
    task automatic pins();
        int m;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        for (int p = 0; p < 6; p++) begin
            m = mask_m[p];
            check("pin_oe", pin_oe[p] & m[7:0], dir_m[p] & m);
            check("pin_out", pin_out[p] & m[7:0], dat_m[p] & dir_m[p] & m);
            check("pull_en", pull_en[p], has_pull[p] ? pull_m[p] & ~dir_m[p] & 255 : 0);
        end
        @(posedge pclk);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 0; p < 6; p++) begin
            pull_m[p] = 0;
            dir_m[p] = 0;
            dat_m[p] = 0;
        end
        @(posedge pclk);
    endtask

    // reset values: pins input, pull-ups off, unused direction bits one
    task automatic reset_values();
        pins();
        for (int p = 0; p < 6; p++) begin
            if (has_pull[p]) apb(0, adr(pull_ix[p]), 0, 0);
            if (has_pull[p]) check("pull reset", rd, 0);
            apb(0, adr(228 + p), 0, 0);
            check("dir read", rd, ~mask_m[p] & 255);
            check("dir err", er, 0);
        end
        idle();
    endtask

    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        summarize();
    end

    initial begin
        for (int p = 0; p < 6; p++) begin
            ext[p] <= 8'h00;
            ext_en[p] <= 8'hFF;
        end
        do_reset();
        reset_values();
        for (int k = 0; k < 5; k++) begin
            for (int p = 0; p < 6; p++) begin
                pull_m[p] = k < 2 ? 255 : $random(seed) & 255;
                dir_m[p] = (k == 0 ? 255 : k == 1 ? 0 : $random(seed) & 255) & mask_m[p];
                dat_m[p] = $random(seed) & mask_m[p];
                ext[p] <= $random(seed);
                ext_en[p] <= k == 4 ? $random(seed) : 8'hFF;
                if (has_pull[p]) apb(1, adr(pull_ix[p]), pull_m[p], 4'hF);
                apb(1, adr(228 + p), {24'($random(seed)), dir_m[p][7:0] | 8'(~mask_m[p])}, 4'hF);
                apb(1, adr(212 + p), dat_m[p], 4'hF);
            end
            idle();
            pins();
            for (int p = 0; p < 6; p++) begin
                if (has_pull[p]) apb(0, adr(pull_ix[p]), 0, 0);
                if (has_pull[p]) check("pull read", rd, pull_m[p]);
                apb(0, adr(212 + p), 0, 0);
                if (k < 4) check("data read", rd, ~mask_m[p] & 255 | dat_m[p] & dir_m[p] | ext[p] & ~dir_m[p] & mask_m[p]);
            end
            idle();
        end
        // unmapped, misaligned and strobe-less accesses leave state alone
        apb(0, adr(240), 0, 0);
        check("unmapped err", er, 1);
        check("unmapped data", rd, 0);
        apb(1, adr(224) | 12'h001, 32'h5A, 4'hF);
        check("misaligned err", er, 1);
        apb(1, adr(224), 32'hA5, 4'h0);
        apb(0, adr(224), 0, 0);
        check("pull kept", rd, pull_m[0]);
        idle();
        // second reset in mid-run
        do_reset();
        reset_values();
        summarize();
    end
endmodule
